// [hw/ras_params.svh]
// Purpose: constants for the return address stack control block
// Assumes: included by bare name; definitions only
// Notes:   offsets are byte addresses on the plain register port
`ifndef RAS_PARAMS_SVH
`define RAS_PARAMS_SVH

`define RAS_ADDR_W        4
`define RAS_OFF_PTR       4'h0
`define RAS_OFF_TOP_LOW   4'h1
`define RAS_OFF_TOP_HIGH  4'h2
`define RAS_OFF_TOP_UPPER 4'h3
`define RAS_OFF_CONFIG    4'h4
`define RAS_BIT_FULL      7
`define RAS_BIT_UNDER     6
`define RAS_LVL_W         5
`define RAS_DEPTH         31
`define RAS_LAST_LEVEL    5'h1F
`define RAS_PC_W          21
`define RAS_PTR_RESET     8'h00
`define RAS_FAULT_PULSE   3'h4

`endif

// [hw/ras_pkg.sv]
// Purpose: types shared by the return address stack control block
// Assumes: ras_params.svh gives the widths
// Notes:   none
`include "ras_params.svh"
package ras_pkg;
    typedef logic [`RAS_LVL_W-1:0] level_t;
    typedef logic [`RAS_PC_W-1:0]  entry_t;
    typedef enum logic [2:0]
    {
        ST_RUN   = 3'h1,
        ST_FAULT = 3'h2,
        ST_HOLD  = 3'h4
    } fault_state_t;
endpackage

// [hw/ras_mem_if.sv]
// Purpose: port bundle between stack control and its entry memory
// Assumes: one write and one read address per cycle
// Notes:   read data are registered inside the memory
`timescale 1ns/1ps
`default_nettype none
interface ras_mem_if;
    import ras_pkg::*;
    logic   we;     // write strobe
    level_t waddr;  // write level
    entry_t wdata;  // write value
    level_t raddr;  // read level
    entry_t rdata;  // registered read value
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// [hw/ras_entry_mem.sv]
// Purpose: storage of the return address entries
// Assumes: synchronous write; read data one cycle after address
// Notes:   write-through so a fresh entry is read back at once
`timescale 1ns/1ps
`default_nettype none
module ras_entry_mem
    import ras_pkg::*;
(
    input  wire logic clk,  // core clock
    ras_mem_if.mem    port  // control side
);
    entry_t store [0:`RAS_DEPTH];  // entry array, level 0 unused

    // write entry, register read data with write-through
    always_ff @(posedge clk)
    begin
        if (port.we)
        begin
            store[port.waddr] <= port.wdata;
        end
        if (port.we && (port.waddr == port.raddr))
        begin
            port.rdata <= port.wdata;
        end
        else
        begin
            port.rdata <= store[port.raddr];
        end
    end
endmodule
`default_nettype wire

// [hw/return_address_stack_ctrl.sv]
// Purpose: return address stack pointer, flags and top entry access
// Assumes: push and pop are one-cycle pulses, never both at once
// Notes:   fault reset is a pulse to the device reset logic
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "ras_params.svh"
module return_address_stack_ctrl
    import ras_pkg::*;
(
    input  wire logic                   clk,                      // core clock 50 MHz
    input  wire logic                   reset_n,                  // power-on reset, low
    input  wire logic                   dev_reset_n,              // other device resets, low
    input  wire logic                   stack_fault_reset_enable, // programmed config bit
    input  wire logic                   push,                     // push pulse from sequencer
    input  wire logic                   pop,                      // pop pulse from sequencer
    input  wire logic [`RAS_PC_W-1:0]   pc,                       // current program counter
    input  wire logic [`RAS_ADDR_W-1:0] addr,                     // register address
    input  wire logic [7:0]             wdata,                    // register write data
    input  wire logic                   wr,                       // write strobe
    input  wire logic                   rd,                       // read strobe
    output logic      [7:0]             rdata,                    // read data, next cycle
    output logic      [`RAS_PC_W-1:0]   top_entry,                // top value for returns
    output logic      [`RAS_LVL_W-1:0]  stack_level,              // current pointer
    output logic                        fault_reset               // device reset request
);
    // bundle towards the entry memory, one write and
    // one read port; entries are not cleared by any reset
    // so a level reads unknown until it has been written
    ras_mem_if mem_port ();

    level_t       lvl_q;               // stack_level_field
    level_t       lvl_d;               // next pointer
    logic         full_q;              // stack_full_flag
    logic         full_d;              // next full flag
    logic         under_q;             // stack_underflow_flag
    logic         under_d;             // next underflow flag
    logic [7:0]   rdata_q;             // read data register
    logic [7:0]   rdata_d;             // next read data
    logic         fault_q;             // fault reset output register
    logic         cfg_q;               // latched config bit
    logic [2:0]   pulse_q;             // fault pulse counter
    fault_state_t state_q;             // fault sequencer state
    fault_state_t state_d;             // next fault state
    logic         run_q;               // low in the first cycle after power-on release

    // address decode and strobe qualification
    // an accepted push or pop outranks a same-cycle pointer write
    // a refused push or pop still raises its flag
    // a push into the last level counts as full
    wire sel_ptr   = (addr == `RAS_OFF_PTR);
    wire sel_low   = (addr == `RAS_OFF_TOP_LOW);
    wire sel_high  = (addr == `RAS_OFF_TOP_HIGH);
    wire sel_upper = (addr == `RAS_OFF_TOP_UPPER);
    wire sel_cfg   = (addr == `RAS_OFF_CONFIG);
    wire wr_ptr    = wr && sel_ptr;
    wire wr_top    = wr && (sel_low || sel_high || sel_upper);
    wire at_last   = (lvl_q == `RAS_LAST_LEVEL);
    wire at_zero   = (lvl_q == 5'h00);
    wire do_push   = push && !at_last;
    wire do_pop    = pop && !at_zero;
    wire set_full  = push && (at_last || (lvl_q == 5'h1E));
    wire set_under = pop && at_zero;
    wire fault_ev  = set_full || set_under;

    // top entry value with a software byte patch applied
    // the patch works on the registered top, so a byte
    // write lands on the entry that reads back now
    // upper window only holds five live bits
    wire entry_t cur_top = mem_port.rdata;
    wire entry_t patched =
        sel_low  ? {cur_top[20:8], wdata} :
        sel_high ? {cur_top[20:16], wdata, cur_top[7:0]} :
                   {wdata[4:0], cur_top[15:0]};

    // memory port: push stores PC at new level, software patches top
    // the read address follows the next pointer, so the
    // registered read data already show the new top
    // one cycle after any push, pop or pointer write
    assign mem_port.we    = do_push || wr_top;
    assign mem_port.waddr = do_push ? level_t'(lvl_q + 5'h01) : lvl_q;
    assign mem_port.wdata = do_push ? pc : patched;
    assign mem_port.raddr = lvl_d;

    // entry memory, read data registered inside
    // with a write-through path for same-level writes
    ras_entry_mem u_mem
    (
        .clk  (clk),
        .port (mem_port)
    );

    // next pointer
    // push and pop move it by one, a software write
    // loads the level field, and a device reset parks
    // it at zero so the read port follows at once
    always_comb
    begin
        lvl_d = lvl_q;
        if (do_push)
        begin
            lvl_d = level_t'(lvl_q + 5'h01);
        end
        else if (do_pop)
        begin
            lvl_d = level_t'(lvl_q - 5'h01);
        end
        else if (wr_ptr)
        begin
            lvl_d = wdata[4:0];
        end
        // a device reset parks the read port on level zero too
        if (!dev_reset_n)
        begin
            lvl_d = 5'h00;
        end
    end

    // sticky flags: set wins over a software clear
    // writing zero to a flag bit clears it, writing one
    // leaves it alone, so software cannot fake a fault
    // a fault in the same cycle as a clear is kept
    always_comb
    begin
        full_d  = full_q;
        under_d = under_q;
        if (wr_ptr && !wdata[`RAS_BIT_FULL])
        begin
            full_d = 1'b0;
        end
        if (wr_ptr && !wdata[`RAS_BIT_UNDER])
        begin
            under_d = 1'b0;
        end
        if (set_full)
        begin
            full_d = 1'b1;
        end
        if (set_under)
        begin
            under_d = 1'b1;
        end
    end

    // read mux, bit 5 of pointer always zero
    // read data are zero outside a read strobe, so the
    // registered value stands for exactly one cycle
    // unmapped offsets read as zero
    always_comb
    begin
        rdata_d = 8'h00;
        if (rd)
        begin
            case (1'b1)
                sel_ptr:   rdata_d = {full_q, under_q, 1'b0, lvl_q};
                sel_low:   rdata_d = cur_top[7:0];
                sel_high:  rdata_d = cur_top[15:8];
                sel_upper: rdata_d = {3'h0, cur_top[20:16]};
                sel_cfg:   rdata_d = {7'h00, cfg_q};
                default:   rdata_d = 8'h00;
            endcase
        end
    end

    // fault sequencer: flag and reset pulse start together
    // flag and request rise on the same edge; the reset
    // that comes back later clears only the pointer
    // further events are ignored until one cycle after the pulse ends
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_RUN:
            begin
                if (fault_ev && cfg_q)
                begin
                    state_d = ST_FAULT;
                end
            end
            ST_FAULT:
            begin
                if (pulse_q == `RAS_FAULT_PULSE)
                begin
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                state_d = ST_RUN;
            end
            default:
            begin
                state_d = ST_RUN;
            end
        endcase
    end

    // flags survive every reset but power-on
    // of the resets only reset_n clears them; dev_reset_n is
    // deliberately not looked at here, so a fault
    // reset cannot wipe the reason it was raised
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            full_q  <= 1'b0;
            under_q <= 1'b0;
        end
        else
        begin
            full_q  <= full_d;
            under_q <= under_d;
        end
    end

    // config bit caught after power-on release
    // the bit is fixed at programming time, so sampling
    // it every clock only costs one cycle of delay
    // before a fault reset can be requested
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            cfg_q <= 1'b0;
        end
        else
        begin
            cfg_q <= stack_fault_reset_enable;
        end
    end

    // pointer, cleared by any reset including a fault reset
    // a fault reset request comes back on dev_reset_n
    // and empties the stack while the flags stay set
    // so software can still read why it happened
    always_ff @(posedge clk)
    begin
        if (!reset_n || !dev_reset_n)
        begin
            lvl_q <= 5'h00;
        end
        else
        begin
            lvl_q <= lvl_d;
        end
    end

    // fault state and pulse counter
    // the counter runs only in the fault state and the
    // output is high for as long as that state lasts
    // giving a fixed length request to the reset logic
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state_q <= ST_RUN;
            pulse_q <= 3'h0;
            fault_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            pulse_q <= (state_d == ST_FAULT) ? 3'(pulse_q + 3'h1) : 3'h0;
            fault_q <= (state_d == ST_FAULT);
        end
    end

    // output registers
    // run_q masks the top entry in the first cycle after
    // power-on release, while the memory read register
    // still holds a value from before the reset
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            rdata_q <= `RAS_PTR_RESET;
            run_q   <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            run_q   <= 1'b1;
        end
    end

    assign rdata       = rdata_q;
    assign top_entry   = run_q ? cur_top : '0;
    assign stack_level = lvl_q;
    assign fault_reset = fault_q;
endmodule
`default_nettype wire

// [tb/ras_chk.sv]
// Purpose: port assertions for the stack control block
// Assumes: one clock, reset_n low clears all but the entries and the memory read register
// Notes:   bind statement sits at the foot
`timescale 1ns/1ps
`default_nettype none
module ras_chk
(
    input wire logic        clk,                      // clock
    input wire logic        reset_n,                  // por
    input wire logic        dev_reset_n,              // device reset
    input wire logic        stack_fault_reset_enable, // config bit
    input wire logic        push,                     // push pulse
    input wire logic        pop,                      // pop pulse
    input wire logic [20:0] pc,                       // program counter
    input wire logic [3:0]  addr,                     // address
    input wire logic        rd,                       // read strobe
    input wire logic [7:0]  rdata,                    // read data
    input wire logic [20:0] top_entry,                // top value
    input wire logic [4:0]  stack_level,              // pointer
    input wire logic        fault_reset               // fault pulse
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!reset_n);
    // push advances the pointer by one
    property p_push_lvl;
        push && dev_reset_n && stack_level != 5'h1F |=> stack_level == $past(stack_level) + 5'h01;
    endproperty
    a_push_lvl: assert property (p_push_lvl) else $error("push level");
    // pushed pc becomes the top value
    property p_push_top;
        push && dev_reset_n && stack_level != 5'h1F |=> top_entry == $past(pc);
    endproperty
    a_push_top: assert property (p_push_top) else $error("push top");
    // pop lowers the pointer by one
    property p_pop_lvl;
        pop && dev_reset_n && stack_level != 5'h00 |=> stack_level == $past(stack_level) - 5'h01;
    endproperty
    a_pop_lvl: assert property (p_pop_lvl) else $error("pop level");
    // refused push keeps the last level
    property p_full_hold;
        push && dev_reset_n && stack_level == 5'h1F |=> stack_level == 5'h1F;
    endproperty
    a_full_hold: assert property (p_full_hold) else $error("full hold");
    // refused pop keeps level zero
    property p_unf_hold;
        pop && dev_reset_n && stack_level == 5'h00 |=> stack_level == 5'h00;
    endproperty
    a_unf_hold: assert property (p_unf_hold) else $error("underflow hold");
    // enabled fault gives a four cycle pulse
    property p_fault_pls;
        $past(stack_fault_reset_enable) && dev_reset_n && !fault_reset &&
        (push && stack_level >= 5'h1E || pop && stack_level == 5'h00)
        |=> fault_reset [*4] ##1 !fault_reset;
    endproperty
    a_fault_pls: assert property (p_fault_pls) else $error("fault pulse");
    // no pulse without the config bit
    property p_no_fault;
        $rose(fault_reset) |-> $past(stack_fault_reset_enable, 2);
    endproperty
    a_no_fault: assert property (p_no_fault) else $error("fault without config");
    // pointer read: bit 5 zero, level field
    property p_rd_ptr;
        rd && addr == 4'h0 |=> rdata[5:0] == {1'b0, $past(stack_level)};
    endproperty
    a_rd_ptr: assert property (p_rd_ptr) else $error("pointer read");
    c_fill: cover property (push && stack_level == 5'h1E);
    c_unf: cover property (pop && stack_level == 5'h00);
    c_fault: cover property ($rose(fault_reset));
endmodule
bind return_address_stack_ctrl ras_chk chk_u (.clk, .reset_n, .dev_reset_n,
    .stack_fault_reset_enable, .push, .pop, .pc, .addr, .rd, .rdata, .top_entry,
    .stack_level, .fault_reset);
`default_nettype wire

// [tb/ras_seq_model.sv]
// Purpose: sequencer model giving push and pop pulses
// Assumes: one pulse per call after gap plus one idle cycles
// Notes:   pc shows the inverse of the last value when idle
`timescale 1ns/1ps
`default_nettype none
module ras_seq_model
(
    input  wire logic        clk,  // clock
    output var  logic        push, // push pulse
    output var  logic        pop,  // pop pulse
    output var  logic [20:0] pc    // program counter
);
    // idle at time zero
    initial
    begin
        push = 1'b0;
        pop = 1'b0;
        pc = 21'h0;
    end
    // one pulse, never push and pop together
    task automatic op(input logic is_push, input logic [20:0] v, input int gap);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        push <= is_push;
        pop <= !is_push;
        pc <= v;
        @(posedge clk);
        push <= 1'b0;
        pop <= 1'b0;
        pc <= ~v;
    endtask
endmodule
`default_nettype wire

// [tb/return_address_stack_ctrl_tb.sv]
// Purpose: register level bench of the stack control block
// Assumes: fault pulse loops back as device reset
// Notes:   one idle cycle between bus calls
`timescale 1ns/1ps
`default_nettype none
module return_address_stack_ctrl_tb
    import ras_pkg::*;
;
    logic        clk, reset_n, dev_reset_n, cfg;  // clock, resets, config
    logic        push, pop, wr, rd, fault;        // strobes, fault pulse
    logic [20:0] pc, top;                         // pc and top value
    logic [3:0]  addr;                            // register address
    logic [7:0]  wdata, rdata;                    // register data
    logic [4:0]  lvl;                             // pointer
    int          fail_count, n_checks;            // counters
    return_address_stack_ctrl dut_u (.clk(clk), .reset_n(reset_n), .dev_reset_n(dev_reset_n),
        .stack_fault_reset_enable(cfg), .push(push), .pop(pop), .pc(pc), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .top_entry(top),
        .stack_level(lvl), .fault_reset(fault));
    ras_seq_model seq_u (.clk(clk), .push(push), .pop(pop), .pc(pc));
    always #10 clk = ~clk;
    // fault pulse fed back as the device reset
    always @(posedge clk) dev_reset_n <= ~fault;
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk({16'h0, rdata}, {16'h0, e});
    endtask
    task automatic top_is(input logic [20:0] e);
        @(posedge clk);
        #1;
        chk({3'h0, top}, {3'h0, e});
    endtask
    // count fault pulse cycles over a fixed window
    task automatic pulse_chk(input logic [23:0] e);
        logic [23:0] n;
        n = 24'h0;
        repeat (12)
        begin
            #1;
            if (fault === 1'b1) n++;
            @(posedge clk);
        end
        chk(n, e);
    endtask
    task automatic print_verdict;
        $display("checks=%0d fails=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // cut a hang short
    initial
    begin
        #200000;
        fail_count++;
        print_verdict;
    end
    initial
    begin
        clk = 1'b0;
        reset_n = 1'b0;
        cfg = 1'b0;
        {wr, rd, addr, wdata} = 14'h0;
        fail_count = 0;
        n_checks = 0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        rd_reg(4'h0, 8'h00);
        rd_reg(4'h4, 8'h00);
        seq_u.op(1'b1, 21'h1ABCDE, 0);
        seq_u.op(1'b1, 21'h0F1234, 2);
        top_is(21'h0F1234);
        rd_reg(4'h0, 8'h02);
        rd_reg(4'h1, 8'h34);
        rd_reg(4'h2, 8'h12);
        rd_reg(4'h3, 8'h0F);
        wr_reg(4'h1, 8'h5A);
        top_is(21'h0F125A);
        seq_u.op(1'b0, 21'h0, 1);
        top_is(21'h1ABCDE);
        rd_reg(4'h0, 8'h01);
        chk({19'h0, lvl}, 24'h000001);
        wr_reg(4'h0, 8'hFF);
        rd_reg(4'h0, 8'h1F);
        chk({19'h0, lvl}, 24'h00001F);
        seq_u.op(1'b1, 21'h000001, 0);
        pulse_chk(24'h0);
        rd_reg(4'h0, 8'h9F);
        wr_reg(4'h0, 8'h00);
        rd_reg(4'h0, 8'h00);
        seq_u.op(1'b0, 21'h0, 0);
        rd_reg(4'h0, 8'h40);
        wr_reg(4'hF, 8'h13);
        rd_reg(4'hF, 8'h00);
        rd_reg(4'h0, 8'h40);
        @(posedge clk);
        cfg <= 1'b1;
        wr_reg(4'h0, 8'h1E);
        rd_reg(4'h4, 8'h01);
        seq_u.op(1'b1, 21'h000002, 0);
        pulse_chk(24'h4);
        rd_reg(4'h0, 8'h80);
        wr_reg(4'h0, 8'h00);
        seq_u.op(1'b0, 21'h0, 0);
        pulse_chk(24'h4);
        rd_reg(4'h0, 8'h40);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd_reg(4'h0, 8'h00);
        print_verdict;
    end
endmodule
`default_nettype wire
